/* cs_port_regs.vh */
`ifndef CS_PORT_REGS_VH
`define CS_PORT_REGS_VH
// Register addresses on the special-function-register bus
`define STROBE_POLARITY_CTRL_ADDR 8'hae
`define PINS_ONE_ZERO_CONFIG_ADDR 8'hc2
`define PINS_THREE_TWO_CONFIG_ADDR 8'hc3
`define NIBBLE_PORT_DATA_ADDR 8'hd8
`define PIN0_BASE_LOW_ADDR 8'h84
`define PIN0_BASE_HIGH_ADDR 8'h85
`define PIN1_BASE_LOW_ADDR 8'h94
`define PIN1_BASE_HIGH_ADDR 8'h95
`define PIN2_BASE_LOW_ADDR 8'hac
`define PIN2_BASE_HIGH_ADDR 8'had
`define PIN3_BASE_LOW_ADDR 8'hb4
`define PIN3_BASE_HIGH_ADDR 8'hb5
// Field positions
`define FUNC_HI_FIELD_MSB 7
`define FUNC_HI_FIELD_LSB 6
`define CMP_HI_FIELD_MSB 5
`define CMP_HI_FIELD_LSB 4
`define FUNC_LO_FIELD_MSB 3
`define FUNC_LO_FIELD_LSB 2
`define CMP_LO_FIELD_MSB 1
`define CMP_LO_FIELD_LSB 0
`define POLARITY_FIELD_MSB 7
`define POLARITY_FIELD_LSB 4
`define PORT_DATA_FIELD_MSB 3
`define PORT_DATA_FIELD_LSB 0
// Encodings
`define FUNC_GPIO 2'b00
`define FUNC_READ 2'b01
`define FUNC_WRITE 2'b10
`define FUNC_BOTH 2'b11
`define CMP_FULL 2'b00
`define CMP_A15_A1 2'b01
`define CMP_A15_A2 2'b10
`define CMP_A15_A8 2'b11
// Reset values
`define CONFIG_RESET 8'h00
`define POLARITY_RESET 4'h0
`define PORT_DATA_RESET 4'hf
`define BASE_RESET 8'h00
`endif

/* addr_matcher.v */
`timescale 1ns/10ps
`include "cs_port_regs.vh"
module addr_matcher #(
    parameter AW = 16
) (
    input wire [AW-1:0] addr,
    input wire [AW-1:0] base,
    input wire [1:0] compare_len,
    output wire match
);
    reg [AW-1:0] care;
    always @* begin
        case (compare_len)
            `CMP_FULL: care = {AW{1'b1}};
            `CMP_A15_A1: care = {{(AW-1){1'b1}}, 1'b0};
            `CMP_A15_A2: care = {{(AW-2){1'b1}}, 2'b00};
            `CMP_A15_A8: care = {{(AW-8){1'b1}}, 8'h00};
            default: care = {AW{1'b1}};
        endcase
    end
    // Differences only in masked bits still match
    assign match = ((addr ^ base) & care) == {AW{1'b0}};
endmodule // addr_matcher

/* cs_port.v */
`timescale 1ns/10ps
`include "cs_port_regs.vh"
module cs_port #(
    parameter AW = 16,
    parameter NPINS = 4
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_we,
    input wire sfr_re,
    output reg [7:0] sfr_rdata,
    output wire sfr_hit,
    input wire [AW-1:0] ext_addr,
    input wire ext_rd_n,
    input wire ext_wr_n,
    input wire [NPINS-1:0] pin_in,
    output wire [NPINS-1:0] pin_out,
    output wire [NPINS-1:0] pin_oe,
    output wire ext_int2_n,
    output wire ext_int3_n
);
    reg [7:0] pins_one_zero_config_q;
    reg [7:0] pins_three_two_config_q;
    reg [3:0] polarity_q;
    reg [3:0] port_data_q;
    reg [7:0] base_high_q [0:NPINS-1];
    reg [7:0] base_low_q [0:NPINS-1];
    reg [1:0] func [0:NPINS-1];
    reg [1:0] cmp [0:NPINS-1];
    wire [NPINS-1:0] match;
    reg [NPINS-1:0] strobe_active;
    reg [NPINS-1:0] pin_drive;
    reg [NPINS-1:0] pin_en;
    integer i;
    integer j;
    integer m;

    function [7:0] base_low_addr;
        input [1:0] idx;
        begin
            case (idx)
                2'd0: base_low_addr = `PIN0_BASE_LOW_ADDR;
                2'd1: base_low_addr = `PIN1_BASE_LOW_ADDR;
                2'd2: base_low_addr = `PIN2_BASE_LOW_ADDR;
                default: base_low_addr = `PIN3_BASE_LOW_ADDR;
            endcase
        end
    endfunction

    function [7:0] base_high_addr;
        input [1:0] idx;
        begin
            case (idx)
                2'd0: base_high_addr = `PIN0_BASE_HIGH_ADDR;
                2'd1: base_high_addr = `PIN1_BASE_HIGH_ADDR;
                2'd2: base_high_addr = `PIN2_BASE_HIGH_ADDR;
                default: base_high_addr = `PIN3_BASE_HIGH_ADDR;
            endcase
        end
    endfunction

    function is_base_addr;
        input [7:0] a;
        integer k;
        begin
            is_base_addr = 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                if (a == base_low_addr(k[1:0]) || a == base_high_addr(k[1:0])) begin
                    is_base_addr = 1'b1;
                end
            end
        end
    endfunction

    // Register writes
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pins_one_zero_config_q <= `CONFIG_RESET;
            pins_three_two_config_q <= `CONFIG_RESET;
            polarity_q <= `POLARITY_RESET;
            port_data_q <= `PORT_DATA_RESET;
            for (i = 0; i < NPINS; i = i + 1) begin
                base_high_q[i] <= `BASE_RESET;
                base_low_q[i] <= `BASE_RESET;
            end
        end else if (sfr_we) begin
            case (sfr_addr)
                `PINS_ONE_ZERO_CONFIG_ADDR: pins_one_zero_config_q <= sfr_wdata;
                `PINS_THREE_TWO_CONFIG_ADDR: pins_three_two_config_q <= sfr_wdata;
                `STROBE_POLARITY_CTRL_ADDR: begin
                    polarity_q <= sfr_wdata[`POLARITY_FIELD_MSB:`POLARITY_FIELD_LSB];
                end
                `NIBBLE_PORT_DATA_ADDR: begin
                    port_data_q <= sfr_wdata[`PORT_DATA_FIELD_MSB:`PORT_DATA_FIELD_LSB];
                end
                default: begin
                    for (i = 0; i < NPINS; i = i + 1) begin
                        if (sfr_addr == base_high_addr(i[1:0])) begin
                            base_high_q[i] <= sfr_wdata;
                        end
                        if (sfr_addr == base_low_addr(i[1:0])) begin
                            base_low_q[i] <= sfr_wdata;
                        end
                    end
                end
            endcase
        end
    end

    // Field extraction per pin
    always @* begin
        func[0] = pins_one_zero_config_q[`FUNC_LO_FIELD_MSB:`FUNC_LO_FIELD_LSB];
        cmp[0] = pins_one_zero_config_q[`CMP_LO_FIELD_MSB:`CMP_LO_FIELD_LSB];
        func[1] = pins_one_zero_config_q[`FUNC_HI_FIELD_MSB:`FUNC_HI_FIELD_LSB];
        cmp[1] = pins_one_zero_config_q[`CMP_HI_FIELD_MSB:`CMP_HI_FIELD_LSB];
        func[2] = pins_three_two_config_q[`FUNC_LO_FIELD_MSB:`FUNC_LO_FIELD_LSB];
        cmp[2] = pins_three_two_config_q[`CMP_LO_FIELD_MSB:`CMP_LO_FIELD_LSB];
        func[3] = pins_three_two_config_q[`FUNC_HI_FIELD_MSB:`FUNC_HI_FIELD_LSB];
        cmp[3] = pins_three_two_config_q[`CMP_HI_FIELD_MSB:`CMP_HI_FIELD_LSB];
    end

    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : gen_pin
            addr_matcher #(
                .AW(AW)
            ) u_match (
                .addr(ext_addr),
                .base({base_high_q[g], base_low_q[g]}),
                .compare_len(cmp[g]),
                .match(match[g])
            );
        end
    endgenerate

    // Strobe is combinational so it tracks the bus strobes in the same cycle
    // Own loop index, so no variable is shared between processes
    always @* begin
        for (j = 0; j < NPINS; j = j + 1) begin
            case (func[j])
                `FUNC_READ: strobe_active[j] = match[j] & ~ext_rd_n;
                `FUNC_WRITE: strobe_active[j] = match[j] & ~ext_wr_n;
                `FUNC_BOTH: strobe_active[j] = match[j] & (~ext_rd_n | ~ext_wr_n);
                default: strobe_active[j] = 1'b0;
            endcase
            if (func[j] == `FUNC_GPIO) begin
                // Quasi-bidirectional: drive only a low, a one floats to the pull-up
                pin_drive[j] = 1'b0;
                pin_en[j] = ~port_data_q[j];
            end else begin
                // Port data bit is ignored while strobing
                pin_drive[j] = strobe_active[j] ~^ polarity_q[j];
                pin_en[j] = 1'b1;
            end
        end
    end

    assign pin_out = pin_drive;
    assign pin_oe = pin_en;

    // Extra interrupt inputs only see the pin in port mode
    assign ext_int2_n = (func[2] == `FUNC_GPIO) ? pin_in[2] : 1'b1;
    assign ext_int3_n = (func[3] == `FUNC_GPIO) ? pin_in[3] : 1'b1;

    assign sfr_hit = (sfr_addr == `PINS_ONE_ZERO_CONFIG_ADDR) ||
                     (sfr_addr == `PINS_THREE_TWO_CONFIG_ADDR) ||
                     (sfr_addr == `STROBE_POLARITY_CTRL_ADDR) ||
                     (sfr_addr == `NIBBLE_PORT_DATA_ADDR) ||
                     is_base_addr(sfr_addr);

    // Read data is registered; port read returns pin levels in the low nibble
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_re) begin
            sfr_rdata <= 8'h00;
            case (sfr_addr)
                `PINS_ONE_ZERO_CONFIG_ADDR: sfr_rdata <= pins_one_zero_config_q;
                `PINS_THREE_TWO_CONFIG_ADDR: sfr_rdata <= pins_three_two_config_q;
                `STROBE_POLARITY_CTRL_ADDR: sfr_rdata <= {polarity_q, 4'h0};
                `NIBBLE_PORT_DATA_ADDR: sfr_rdata <= {4'h0, pin_in};
                default: begin
                    for (m = 0; m < NPINS; m = m + 1) begin
                        if (sfr_addr == base_high_addr(m[1:0])) begin
                            sfr_rdata <= base_high_q[m];
                        end
                        if (sfr_addr == base_low_addr(m[1:0])) begin
                            sfr_rdata <= base_low_q[m];
                        end
                    end
                end
            endcase
        end
    end
endmodule // cs_port

/* cs_port_asserts.sv */
`timescale 1ns/10ps
`include "cs_port_regs.vh"
module cs_port_asserts #(
    parameter NPINS = 4
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_we,
    input wire sfr_re,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire ext_rd_n,
    input wire ext_wr_n,
    input wire [NPINS-1:0] pin_in,
    input wire [NPINS-1:0] pin_out,
    input wire [NPINS-1:0] pin_oe,
    input wire ext_int2_n
);
    // Shadow of the configuration so each pin's mode is known from the bus alone
    reg [15:0] cfg_q;
    reg [3:0] pol_q;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= 16'h0000;
            pol_q <= 4'h0;
        end else if (sfr_we) begin
            if (sfr_addr == `PINS_ONE_ZERO_CONFIG_ADDR) cfg_q[7:0] <= sfr_wdata;
            if (sfr_addr == `PINS_THREE_TWO_CONFIG_ADDR) cfg_q[15:8] <= sfr_wdata;
            if (sfr_addr == `STROBE_POLARITY_CTRL_ADDR) pol_q <= sfr_wdata[7:4];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    unmapped_read_zero_a: assert property (sfr_re && !sfr_hit |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    read_data_holds_a: assert property (!sfr_re |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    config_readback_a: assert property (sfr_re && !sfr_we && sfr_addr == 8'hc3 |=> sfr_rdata == cfg_q[15:8])
        else $error("upper config readback wrong");
    int_route_a: assert property (ext_int2_n == (cfg_q[11:10] == 2'b00 ? pin_in[2] : 1'b1))
        else $error("interrupt input routing wrong");
    genvar i;
    for (i = 0; i < 4; i = i + 1) begin : g_pin
        wire [1:0] fn = cfg_q[4*i+3 -: 2];
        gpio_low_drive_a: assert property (fn == `FUNC_GPIO |-> !pin_out[i])
            else $error("port bit drives high");
        strobe_driven_a: assert property (fn != `FUNC_GPIO |-> pin_oe[i])
            else $error("strobe pin not driven");
        read_only_a: assert property (fn == `FUNC_READ && ext_rd_n |-> pin_out[i] == ~pol_q[i])
            else $error("read strobe active without read");
        write_only_a: assert property (fn == `FUNC_WRITE && ext_wr_n |-> pin_out[i] == ~pol_q[i])
            else $error("write strobe active without write");
        both_idle_a: assert property (fn == `FUNC_BOTH && ext_rd_n && ext_wr_n |-> pin_out[i] == ~pol_q[i])
            else $error("strobe active outside bus cycle");
    end
endmodule // cs_port_asserts
bind cs_port cs_port_asserts #(.NPINS(NPINS)) u_cs_port_asserts (.sys_clk(sys_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ext_int2_n(ext_int2_n));

/* pad_pullup.sv */
`timescale 1ns/10ps
module pad_pullup (
    input wire [3:0] pin_out,
    input wire [3:0] pin_oe,
    output wire [3:0] pin_in
);
    // Undriven pads float up through the pull-up, as on a quasi-bidirectional port
    assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule // pad_pullup

/* cs_port_bench.sv */
`timescale 1ns/10ps
`include "cs_port_regs.vh"
module cs_port_bench;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] sfr_addr = 8'h00;
    reg [7:0] sfr_wdata = 8'h00;
    reg sfr_we = 1'b0;
    reg sfr_re = 1'b0;
    reg [15:0] ext_addr = 16'h0000;
    reg ext_rd_n = 1'b1;
    reg ext_wr_n = 1'b1;
    wire [7:0] sfr_rdata;
    wire sfr_hit;
    wire [3:0] pin_in;
    wire [3:0] pin_out;
    wire [3:0] pin_oe;
    wire ext_int2_n;
    wire ext_int3_n;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer f, c, k;
    reg [15:0] flip;
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    cs_port u_cs_port (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_int2_n(ext_int2_n), .ext_int3_n(ext_int3_n));
    pad_pullup u_pad_pullup (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task check(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task sfr_wr(input [7:0] a, input [7:0] d);
        begin
            sfr_addr <= a;
            sfr_wdata <= d;
            sfr_we <= 1'b1;
            @(posedge sys_clk);
            sfr_we <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task sfr_rd(input [7:0] a, input [7:0] exp);
        begin
            sfr_addr <= a;
            sfr_re <= 1'b1;
            @(posedge sys_clk);
            sfr_re <= 1'b0;
            @(posedge sys_clk);
            #1 check(sfr_rdata, exp);
            @(posedge sys_clk);
        end
    endtask
    // Strobe is combinational, so it is sampled inside the bus cycle itself
    task ext_cyc(input [15:0] a, input rd, input [1:0] p, input e);
        begin
            ext_addr <= a;
            ext_rd_n <= ~rd;
            ext_wr_n <= rd;
            @(posedge sys_clk);
            #1 check(pin_out[p], e);
            @(posedge sys_clk);
            ext_rd_n <= 1'b1;
            ext_wr_n <= 1'b1;
            @(posedge sys_clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares=%0d mismatches=%0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    initial begin
        #200000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sfr_rd(`PINS_THREE_TWO_CONFIG_ADDR, 8'h00);
        sfr_rd(`STROBE_POLARITY_CTRL_ADDR, 8'h00);
        sfr_rd(`NIBBLE_PORT_DATA_ADDR, 8'h0f);
        sfr_rd(8'h80, 8'h00);
        sfr_wr(`PIN0_BASE_HIGH_ADDR, 8'h12);
        sfr_wr(`PIN0_BASE_LOW_ADDR, 8'h34);
        sfr_wr(`STROBE_POLARITY_CTRL_ADDR, 8'h10);
        sfr_wr(`PINS_ONE_ZERO_CONFIG_ADDR, 8'h0a);
        sfr_rd(`PIN0_BASE_HIGH_ADDR, 8'h12);
        for (k = 0; k < 6; k = k + 1) begin
            ext_cyc(16'h1233 + k[15:0], 1'b0, 2'd0, k >= 1 && k <= 4);
            ext_cyc(16'h1233 + k[15:0], 1'b1, 2'd0, 1'b0);
        end
        sfr_wr(`PIN1_BASE_HIGH_ADDR, 8'h5a);
        sfr_wr(`PIN1_BASE_LOW_ADDR, 8'h5a);
        for (f = 1; f < 4; f = f + 1) begin
            for (c = 0; c < 4; c = c + 1) begin
                sfr_wr(`PINS_ONE_ZERO_CONFIG_ADDR, {f[1:0], c[1:0], 4'ha});
                for (k = 0; k < 5; k = k + 1) begin
                    flip = k == 0 ? 16'h0 : k == 1 ? 16'h1 : k == 2 ? 16'h2 : k == 3 ? 16'h80 : 16'h100;
                    ext_cyc(16'h5a5a ^ flip, 1'b1, 2'd1, ~(k <= c && f[0]));
                    ext_cyc(16'h5a5a ^ flip, 1'b0, 2'd1, ~(k <= c && f[1]));
                end
            end
        end
        sfr_wr(`PINS_ONE_ZERO_CONFIG_ADDR, 8'h00);
        sfr_wr(`NIBBLE_PORT_DATA_ADDR, 8'hf5);
        sfr_rd(`NIBBLE_PORT_DATA_ADDR, 8'h05);
        check({pin_oe, ext_int3_n, ext_int2_n}, 6'h29);
        sfr_wr(`PINS_THREE_TWO_CONFIG_ADDR, 8'hc0);
        check({pin_oe[3], pin_out[3], ext_int3_n}, 3'h7);
        ext_cyc(16'h0000, 1'b1, 2'd3, 1'b0);
        tally_and_finish;
    end
endmodule // cs_port_bench
